// *** hw/interrupt_request_dispatch.v ***
`include "irq_dispatch_regs.vh"
`default_nettype none

module interrupt_request_dispatch #(
    parameter NUM_MASKABLE = `NUM_MASKABLE
) (
    input wire MCLK_I,
    input wire RESET_I,
    input wire CE_I,
    // Request sources, one-cycle pulses
    input wire NMI_EDGE_I,
    input wire WATCHDOG_OVERFLOW_REQ_I,
    input wire VECTORED_BREAK_INSTR_I,
    input wire CONTEXT_BREAK_INSTR_I,
    input wire [7:0] CONTEXT_BREAK_BANK_I,
    input wire STANDBY_CONTROL_WRITE_BAD_I,
    input wire WATCHDOG_MODE_WRITE_BAD_I,
    input wire RELOCATION_INSTR_BAD_I,
    input wire EXT_EDGE_REQ_0_I,
    input wire EXT_EDGE_REQ_1_I,
    input wire EXT_EDGE_REQ_2_I,
    input wire EXT_EDGE_REQ_3_I,
    input wire TMR0_MATCH_REQ_A_I,
    input wire TMR0_MATCH_REQ_B_I,
    input wire TMR1_NARROW_MATCH_A_I,
    input wire TMR1_WIDE_MATCH_A_I,
    input wire TMR1_NARROW_MATCH_B_I,
    input wire TMR1_WIDE_MATCH_B_I,
    input wire TMR2_NARROW_MATCH_A_I,
    input wire TMR2_WIDE_MATCH_A_I,
    // Per-source control, one bit per source (two for the level), source 0 in the low bits
    input wire [NUM_MASKABLE-1:0] MASK_I,
    input wire [2*NUM_MASKABLE-1:0] PRIO_LEVEL_I,
    input wire [NUM_MASKABLE-1:0] USE_CONTEXT_I,
    input wire [NUM_MASKABLE-1:0] USE_MACRO_I,
    input wire [NUM_MASKABLE-1:0] MACRO_CAPABLE_I,
    input wire GLOBAL_IRQ_ENABLE_I,
    // Core handshake
    input wire CORE_READY_I,
    input wire SERVICE_DONE_I,
    // Dispatch outputs
    output reg DISPATCH_O,
    output reg [2:0] DISPATCH_MODE_O,
    output reg [2:0] DISPATCH_KIND_O,
    output reg [7:0] DISPATCH_VECTOR_O,
    output reg [15:0] MACRO_WORD_ADDR_O,
    output reg [7:0] BANK_SEL_O,
    output reg SAVE_TO_STACK_O,
    output reg SAVE_TO_BANK_O,
    output reg [NUM_MASKABLE-1:0] PENDING_O,
    output reg [2:0] IN_SERVICE_LEVEL_O,
    output reg NMI_IN_SERVICE_O
);

    // ========================================
    // Source collection
    // ========================================
    wire [NUM_MASKABLE-1:0] raw_req;
    wire [NUM_MASKABLE-1:0] pend;
    wire operand_err;

    assign raw_req[6] = TMR1_NARROW_MATCH_A_I | TMR1_WIDE_MATCH_A_I;
    assign raw_req[7] = TMR1_NARROW_MATCH_B_I | TMR1_WIDE_MATCH_B_I;
    assign raw_req[8] = TMR2_NARROW_MATCH_A_I | TMR2_WIDE_MATCH_A_I;
    assign raw_req[3:0] = {EXT_EDGE_REQ_3_I, EXT_EDGE_REQ_2_I,
                           EXT_EDGE_REQ_1_I, EXT_EDGE_REQ_0_I};
    assign raw_req[5:4] = {TMR0_MATCH_REQ_B_I, TMR0_MATCH_REQ_A_I};
    assign operand_err = STANDBY_CONTROL_WRITE_BAD_I | WATCHDOG_MODE_WRITE_BAD_I |
                         RELOCATION_INSTR_BAD_I;

    // Fixed sources latched until taken
    reg nmi_pin_pend_r;
    reg wdt_pend_r;
    reg opr_pend_r;
    reg vbreak_pend_r;
    reg ctx_pend_r;
    reg [7:0] ctx_bank_r;

    // ========================================
    // Acceptance
    // ========================================
    reg [NUM_MASKABLE-1:0] accept_clr_nxt;
    reg [NUM_MASKABLE-1:0] accept_clr_r;
    reg nmi_stack_pin_r;
    reg nmi_stack_wdt_r;
    reg [3:0] level_stack_r;
    reg [2:0] cur_level_nxt;

    genvar g;
    generate
        for (g = 0; g < NUM_MASKABLE; g = g + 1) begin : pend_gen
            pending_flag u_flag (
                .clk_i(MCLK_I),
                .rst_i(RESET_I),
                .ce_i(CE_I),
                .set_i(raw_req[g]),
                .clr_i(accept_clr_r[g]),
                .flag_o(pend[g])
            );
        end
    endgenerate

    // Macro requests bypass the level and global enable
    wire [NUM_MASKABLE-1:0] macro_ok = USE_MACRO_I & MACRO_CAPABLE_I;
    wire [NUM_MASKABLE-1:0] live = pend & ~accept_clr_r;
    wire [NUM_MASKABLE-1:0] vec_req = live & ~MASK_I & ~macro_ok &
                                      {NUM_MASKABLE{GLOBAL_IRQ_ENABLE_I}};
    wire [NUM_MASKABLE-1:0] mac_req = live & ~MASK_I & macro_ok;

    wire vec_found;
    wire [3:0] vec_idx;
    wire [1:0] vec_lvl;
    wire mac_found;
    wire [3:0] mac_idx;

    prio_pick #(.N(NUM_MASKABLE)) u_vec_pick (
        .req_i(vec_req),
        .level_i(PRIO_LEVEL_I),
        .found_o(vec_found),
        .index_o(vec_idx),
        .level_o(vec_lvl)
    );

    prio_pick #(.N(NUM_MASKABLE)) u_mac_pick (
        .req_i(mac_req),
        .level_i({2*NUM_MASKABLE{1'b0}}),
        .found_o(mac_found),
        .index_o(mac_idx),
        .level_o()
    );

    // Current level, 3'h4 means none in service
    wire [2:0] cur_level = IN_SERVICE_LEVEL_O;
    // Nest only above the running level
    wire vec_may = vec_found && ({1'b0, vec_lvl} < cur_level);

    // One-hot selection of the acceptance state machine
    localparam ST_IDLE = 2'b01;
    localparam ST_HOLD = 2'b10;
    reg [1:0] state_r;

    reg take;
    reg [2:0] kind;
    reg [2:0] mode;
    reg [7:0] vec;
    reg [15:0] mscw;
    reg [7:0] bank;
    reg [3:0] idx;

    always @* begin
        take = 1'b0;
        kind = `KIND_NONE;
        mode = `MODE_VECTORED;
        vec = 8'h00;
        mscw = 16'h0000;
        bank = 8'h00;
        idx = 4'h0;
        accept_clr_nxt = {NUM_MASKABLE{1'b0}};
        // Non-maskable first, no enables; pin may nest over watchdog
        if (nmi_pin_pend_r && !nmi_stack_pin_r) begin
            take = 1'b1;
            kind = `KIND_NMI_PIN;
            vec = `VEC_NMI_PIN;
        end else if (wdt_pend_r && !nmi_stack_wdt_r && !nmi_stack_pin_r) begin
            take = 1'b1;
            kind = `KIND_WATCHDOG;
            vec = `VEC_WATCHDOG;
        end else if (opr_pend_r) begin
            take = 1'b1;
            kind = `KIND_OPERAND;
            vec = `VEC_OPERAND_ERR;
        end else if (vbreak_pend_r) begin
            take = 1'b1;
            kind = `KIND_SW_BREAK;
            vec = `VEC_SW_BREAK;
        end else if (ctx_pend_r) begin
            take = 1'b1;
            kind = `KIND_CTX_BREAK;
            mode = `MODE_CONTEXT;
            bank = ctx_bank_r;
        end else if (mac_found) begin
            take = 1'b1;
            kind = `KIND_MASKABLE;
            idx = mac_idx;
            mode = `MODE_MACRO;
            accept_clr_nxt[mac_idx] = 1'b1;
        end else if (vec_may) begin
            take = 1'b1;
            kind = `KIND_MASKABLE;
            idx = vec_idx;
            mode = USE_CONTEXT_I[vec_idx] ? `MODE_CONTEXT : `MODE_VECTORED;
            accept_clr_nxt[vec_idx] = 1'b1;
        end
        if (kind == `KIND_MASKABLE) begin
            // Maskable entries and control words, two apart per source
            vec = `VEC_MASKABLE_BASE + {3'h0, idx, 1'b0};
            mscw = `MSCW_BASE + {11'h000, idx, 1'b0};
            bank = vec;
        end
        cur_level_nxt = (take && kind == `KIND_MASKABLE && mode != `MODE_MACRO) ?
                        {1'b0, vec_lvl} : cur_level;
    end

    // ========================================
    // Registers
    // ========================================
    always @(posedge MCLK_I) begin
        if (RESET_I) begin
            state_r <= ST_IDLE;
            nmi_pin_pend_r <= 1'b0;
            wdt_pend_r <= 1'b0;
            opr_pend_r <= 1'b0;
            vbreak_pend_r <= 1'b0;
            ctx_pend_r <= 1'b0;
            ctx_bank_r <= 8'h00;
            accept_clr_r <= {NUM_MASKABLE{1'b0}};
            nmi_stack_pin_r <= 1'b0;
            nmi_stack_wdt_r <= 1'b0;
            level_stack_r <= 4'h0;
            DISPATCH_O <= 1'b0;
            DISPATCH_MODE_O <= `MODE_VECTORED;
            DISPATCH_KIND_O <= `KIND_NONE;
            DISPATCH_VECTOR_O <= 8'h00;
            MACRO_WORD_ADDR_O <= 16'h0000;
            BANK_SEL_O <= 8'h00;
            SAVE_TO_STACK_O <= 1'b0;
            SAVE_TO_BANK_O <= 1'b0;
            PENDING_O <= {NUM_MASKABLE{1'b0}};
            IN_SERVICE_LEVEL_O <= 3'h4;
            NMI_IN_SERVICE_O <= 1'b0;
        end else if (CE_I) begin
            PENDING_O <= pend;
            accept_clr_r <= {NUM_MASKABLE{1'b0}};
            DISPATCH_O <= 1'b0;
            SAVE_TO_STACK_O <= 1'b0;
            SAVE_TO_BANK_O <= 1'b0;
            nmi_pin_pend_r <= nmi_pin_pend_r | NMI_EDGE_I;
            wdt_pend_r <= wdt_pend_r | WATCHDOG_OVERFLOW_REQ_I;
            opr_pend_r <= opr_pend_r | operand_err;
            vbreak_pend_r <= vbreak_pend_r | VECTORED_BREAK_INSTR_I;
            if (CONTEXT_BREAK_INSTR_I) begin
                ctx_pend_r <= 1'b1;
                ctx_bank_r <= CONTEXT_BREAK_BANK_I;
            end
            case (state_r)
                ST_IDLE: begin
                    if (take && CORE_READY_I) begin
                        DISPATCH_O <= 1'b1;
                        DISPATCH_MODE_O <= mode;
                        DISPATCH_KIND_O <= kind;
                        DISPATCH_VECTOR_O <= vec;
                        MACRO_WORD_ADDR_O <= mscw;
                        BANK_SEL_O <= bank;
                        SAVE_TO_STACK_O <= (mode == `MODE_VECTORED);
                        SAVE_TO_BANK_O <= (mode == `MODE_CONTEXT);
                        // Macro leaves PC and status word
                        accept_clr_r <= accept_clr_nxt;
                        state_r <= ST_HOLD;
                        case (kind)
                            `KIND_NMI_PIN: begin
                                nmi_pin_pend_r <= NMI_EDGE_I;
                                nmi_stack_pin_r <= 1'b1;
                                NMI_IN_SERVICE_O <= 1'b1;
                            end
                            `KIND_WATCHDOG: begin
                                wdt_pend_r <= WATCHDOG_OVERFLOW_REQ_I;
                                nmi_stack_wdt_r <= 1'b1;
                                NMI_IN_SERVICE_O <= 1'b1;
                            end
                            `KIND_OPERAND: opr_pend_r <= operand_err;
                            `KIND_SW_BREAK: vbreak_pend_r <= VECTORED_BREAK_INSTR_I;
                            `KIND_CTX_BREAK: ctx_pend_r <= CONTEXT_BREAK_INSTR_I;
                            default: begin
                                if (mode != `MODE_MACRO) begin
                                    level_stack_r[cur_level_nxt[1:0]] <= 1'b1;
                                    IN_SERVICE_LEVEL_O <= cur_level_nxt;
                                end
                            end
                        endcase
                    end else if (SERVICE_DONE_I) begin
                        // Return closes an open pin or watchdog service first, pin before watchdog, else the running level
                        if (nmi_stack_pin_r || nmi_stack_wdt_r) begin
                            if (nmi_stack_pin_r) begin
                                nmi_stack_pin_r <= 1'b0;
                            end else begin
                                nmi_stack_wdt_r <= 1'b0;
                            end
                            NMI_IN_SERVICE_O <= nmi_stack_pin_r && nmi_stack_wdt_r;
                        end else if (IN_SERVICE_LEVEL_O != 3'h4) begin
                            level_stack_r[IN_SERVICE_LEVEL_O[1:0]] <= 1'b0;
                            IN_SERVICE_LEVEL_O <= next_level(level_stack_r &
                                ~(4'h1 << IN_SERVICE_LEVEL_O[1:0]));
                        end
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // Highest-priority level still open
    function [2:0] next_level;
        input [3:0] stack;
        begin
            if (stack[0]) begin
                next_level = 3'h0;
            end else if (stack[1]) begin
                next_level = 3'h1;
            end else if (stack[2]) begin
                next_level = 3'h2;
            end else if (stack[3]) begin
                next_level = 3'h3;
            end else begin
                next_level = 3'h4;
            end
        end
    endfunction

endmodule

`default_nettype wire

// *** hw/irq_dispatch_regs.vh ***
`ifndef IRQ_DISPATCH_REGS_VH
`define IRQ_DISPATCH_REGS_VH

// Vector-table entries of the fixed sources
`define VEC_NMI_PIN 8'h02
`define VEC_WATCHDOG 8'h04
`define VEC_OPERAND_ERR 8'h3C
`define VEC_SW_BREAK 8'h3E
// First maskable vector entry, and the step between two entries
`define VEC_MASKABLE_BASE 8'h06
`define VEC_STEP 8'h02
// Macro service control words for maskable sources
`define MSCW_BASE 16'hFE06
`define MSCW_STEP 16'h0002

// Number of maskable sources handled here
`define NUM_MASKABLE 9
// Number of programmable priority levels
`define NUM_PRIO_LEVELS 4

// Service modes, one-hot
`define MODE_VECTORED 3'h1
`define MODE_CONTEXT 3'h2
`define MODE_MACRO 3'h4

// Kind of accepted request, encoded
`define KIND_NONE 3'h0
`define KIND_NMI_PIN 3'h1
`define KIND_WATCHDOG 3'h2
`define KIND_OPERAND 3'h3
`define KIND_SW_BREAK 3'h4
`define KIND_CTX_BREAK 3'h5
`define KIND_MASKABLE 3'h6

`endif

// *** hw/pending_flag.v ***
`default_nettype none

// Pending flag for one maskable source; a new request wins over the clear
module pending_flag (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire set_i,
    input wire clr_i,
    output reg flag_o
);

    always @(posedge clk_i) begin
        if (rst_i) begin
            flag_o <= 1'b0;
        end else if (ce_i) begin
            if (set_i) begin
                flag_o <= 1'b1;
            end else if (clr_i) begin
                flag_o <= 1'b0;
            end
        end
    end

endmodule

`default_nettype wire

// *** hw/prio_pick.v ***
`default_nettype none

// Lowest-index winner among requests at the best (numerically lowest) level
module prio_pick #(
    parameter N = 9
) (
    input wire [N-1:0] req_i,
    input wire [2*N-1:0] level_i,
    output reg found_o,
    output reg [3:0] index_o,
    output reg [1:0] level_o
);

    integer i;

    always @* begin
        found_o = 1'b0;
        index_o = 4'h0;
        level_o = 2'h3;
        for (i = 0; i < N; i = i + 1) begin
            if (req_i[i] && (!found_o || level_i[2*i +: 2] < level_o)) begin
                found_o = 1'b1;
                index_o = i[3:0];
                level_o = level_i[2*i +: 2];
            end
        end
    end

endmodule

`default_nettype wire

// *** test/interrupt_request_dispatch_assertions.sv ***
`default_nettype none
module irq_dispatch_checker #(
    parameter NUM_MASKABLE = 9
) (
    input wire logic MCLK_I,
    input wire logic RESET_I,
    input wire logic CE_I,
    input wire logic NMI_EDGE_I,
    input wire logic GLOBAL_IRQ_ENABLE_I,
    input wire logic DISPATCH_O,
    input wire logic [2:0] DISPATCH_MODE_O,
    input wire logic [2:0] DISPATCH_KIND_O,
    input wire logic [7:0] DISPATCH_VECTOR_O,
    input wire logic [15:0] MACRO_WORD_ADDR_O,
    input wire logic [7:0] BANK_SEL_O,
    input wire logic SAVE_TO_STACK_O,
    input wire logic SAVE_TO_BANK_O,
    input wire logic NMI_IN_SERVICE_O
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge MCLK_I);
    endclocking
    default disable iff (RESET_I);
    // ==========================================================
    // Dispatch steps
    sequence s_vec_entry(logic [7:0] v);
        DISPATCH_VECTOR_O == v && DISPATCH_MODE_O == 3'h1
            && SAVE_TO_STACK_O && !SAVE_TO_BANK_O;
    endsequence
    sequence s_nmi_taken;
        NMI_EDGE_I && CE_I && !NMI_IN_SERVICE_O && !DISPATCH_O;
    endsequence
    // ==========================================================
    // Properties
    a_nmi_pin_vec: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h1 |-> s_vec_entry(8'h02))
        else $error("pin request dispatched with wrong entry");
    a_watchdog_vec: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h2 |-> s_vec_entry(8'h04))
        else $error("watchdog request dispatched with wrong entry");
    a_operand_err_vec: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h3 |-> s_vec_entry(8'h3C))
        else $error("operand error dispatched with wrong entry");
    a_break_vec: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h4 |-> s_vec_entry(8'h3E))
        else $error("vectored break dispatched with wrong entry");
    a_ctx_break_mode: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h5 |->
            DISPATCH_MODE_O == 3'h2 && SAVE_TO_BANK_O && !SAVE_TO_STACK_O)
        else $error("context break not serviced by bank switch");
    a_mask_table: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h6 |->
            MACRO_WORD_ADDR_O == {8'hFE, DISPATCH_VECTOR_O} && !DISPATCH_VECTOR_O[0]
            && DISPATCH_VECTOR_O >= 8'h06 && DISPATCH_VECTOR_O <= 8'h16)
        else $error("maskable entry or control word out of table");
    a_macro_quiet: assert property (
        DISPATCH_O && DISPATCH_MODE_O == 3'h4 |->
            DISPATCH_KIND_O == 3'h6 && !SAVE_TO_STACK_O && !SAVE_TO_BANK_O)
        else $error("macro service touched context or wrong source");
    a_ctx_bank_sel: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h6 && DISPATCH_MODE_O == 3'h2 |->
            BANK_SEL_O == DISPATCH_VECTOR_O && SAVE_TO_BANK_O)
        else $error("context switch names wrong bank");
    a_enable_gate: assert property (
        DISPATCH_O && DISPATCH_KIND_O == 3'h6 && DISPATCH_MODE_O != 3'h4 |->
            $past(GLOBAL_IRQ_ENABLE_I))
        else $error("maskable accepted with interrupts disabled");
    a_dispatch_gap: assert property (
        DISPATCH_O && CE_I |=> !DISPATCH_O)
        else $error("dispatch pulses back to back");
    a_nmi_first: assert property (
        s_nmi_taken |=> ##1 !(DISPATCH_O && DISPATCH_KIND_O != 3'h1))
        else $error("other request ranked above pin request");
endmodule
`default_nettype wire

// *** test/irq_core_model.sv ***
`default_nettype none
module irq_core_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic dispatch_i,
    input wire logic [2:0] mode_i,
    input wire logic stall_i,
    input wire logic [4:0] delay_i,
    output logic ready_o,
    output logic done_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] depth;
    logic [4:0] timer;
    assign ready_o = !stall_i;
    always @(negedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            depth <= 4'h0;
            timer <= 5'h0;
        // routine entered at its base-area entry, runs, returns
        end else if (dispatch_i && mode_i != 3'h4) begin
            depth <= depth + 4'h1;
            timer <= delay_i;
        end else if (depth != 4'h0 && timer != 5'h0) begin
            timer <= timer - 5'h1;
        end else if (depth != 4'h0) begin
            done_o <= 1'b1;
            depth <= depth - 4'h1;
            timer <= delay_i;
        end
    end
endmodule
`default_nettype wire

// *** test/interrupt_request_dispatch_test.sv ***
`default_nettype none
bind interrupt_request_dispatch irq_dispatch_checker #(.NUM_MASKABLE(NUM_MASKABLE)) i_chk (
    .MCLK_I(MCLK_I), .RESET_I(RESET_I), .CE_I(CE_I), .NMI_EDGE_I(NMI_EDGE_I),
    .GLOBAL_IRQ_ENABLE_I(GLOBAL_IRQ_ENABLE_I), .DISPATCH_O(DISPATCH_O),
    .DISPATCH_MODE_O(DISPATCH_MODE_O), .DISPATCH_KIND_O(DISPATCH_KIND_O),
    .DISPATCH_VECTOR_O(DISPATCH_VECTOR_O), .MACRO_WORD_ADDR_O(MACRO_WORD_ADDR_O),
    .BANK_SEL_O(BANK_SEL_O), .SAVE_TO_STACK_O(SAVE_TO_STACK_O),
    .SAVE_TO_BANK_O(SAVE_TO_BANK_O), .NMI_IN_SERVICE_O(NMI_IN_SERVICE_O));
module interrupt_request_dispatch_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst, gie, stall, ce, ready, done, disp, stk, bnk, nmis;
    logic [18:0] src;
    logic [8:0] mask, use_ctx, use_mac, cap, pend;
    logic [17:0] lvl;
    logic [7:0] bank, vec, bsel;
    logic [4:0] dly;
    logic [2:0] mode, kind, isl;
    logic [15:0] mscw;
    int miscompares, comparisons;
    interrupt_request_dispatch i_dut (
        .MCLK_I(clk), .RESET_I(rst), .CE_I(ce), .NMI_EDGE_I(src[0]),
        .WATCHDOG_OVERFLOW_REQ_I(src[1]), .VECTORED_BREAK_INSTR_I(src[2]),
        .CONTEXT_BREAK_INSTR_I(src[3]), .CONTEXT_BREAK_BANK_I(bank),
        .STANDBY_CONTROL_WRITE_BAD_I(src[4]), .WATCHDOG_MODE_WRITE_BAD_I(src[5]),
        .RELOCATION_INSTR_BAD_I(src[6]), .EXT_EDGE_REQ_0_I(src[7]),
        .EXT_EDGE_REQ_1_I(src[8]), .EXT_EDGE_REQ_2_I(src[9]), .EXT_EDGE_REQ_3_I(src[10]),
        .TMR0_MATCH_REQ_A_I(src[11]), .TMR0_MATCH_REQ_B_I(src[12]),
        .TMR1_NARROW_MATCH_A_I(src[13]), .TMR1_WIDE_MATCH_A_I(src[14]),
        .TMR1_NARROW_MATCH_B_I(src[15]), .TMR1_WIDE_MATCH_B_I(src[16]),
        .TMR2_NARROW_MATCH_A_I(src[17]), .TMR2_WIDE_MATCH_A_I(src[18]),
        .MASK_I(mask), .PRIO_LEVEL_I(lvl), .USE_CONTEXT_I(use_ctx), .USE_MACRO_I(use_mac),
        .MACRO_CAPABLE_I(cap), .GLOBAL_IRQ_ENABLE_I(gie), .CORE_READY_I(ready),
        .SERVICE_DONE_I(done), .DISPATCH_O(disp), .DISPATCH_MODE_O(mode),
        .DISPATCH_KIND_O(kind), .DISPATCH_VECTOR_O(vec), .MACRO_WORD_ADDR_O(mscw),
        .BANK_SEL_O(bsel), .SAVE_TO_STACK_O(stk), .SAVE_TO_BANK_O(bnk), .PENDING_O(pend),
        .IN_SERVICE_LEVEL_O(isl), .NMI_IN_SERVICE_O(nmis));
    irq_core_model i_core (.clk_i(clk), .rst_i(rst), .dispatch_i(disp), .mode_i(mode),
        .stall_i(stall), .delay_i(dly), .ready_o(ready), .done_o(done));
    // ==========================================================
    // Helpers
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        comparisons++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic pulse2(input int a, input int b);
        src[a] = 1'b1;
        src[b] = 1'b1;
        @(negedge clk);
        src = '0;
    endtask
    task automatic expect_disp(input logic [2:0] k, input logic [2:0] m, input logic [7:0] v,
                               input logic [15:0] w);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (disp !== 1'b1 && n < 60);
        chk("dispatch", 16'h1, 16'(disp));
        chk("kind", 16'(k), 16'(kind));
        chk("mode", 16'(m), 16'(mode));
        if (k != 3'h5)
            chk("vector", 16'(v), 16'(vec));
        chk("word", w, mscw);
        chk("stack save", 16'(m == 3'h1), 16'(stk));
        chk("bank save", 16'(m == 3'h2), 16'(bnk));
    endtask
    task automatic expect_none(input int c);
        int hits;
        hits = 0;
        repeat (c) begin
            @(negedge clk);
            if (disp === 1'b1)
                hits++;
        end
        chk("quiet", 16'h0, 16'(hits));
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while ((i_core.depth != 4'h0 || isl !== 3'h4 || nmis !== 1'b0) && n < 90) begin
            @(negedge clk);
            n++;
        end
        repeat (3) @(negedge clk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_fixed();
        logic [2:0] fk [7] = '{3'h1, 3'h2, 3'h4, 3'h5, 3'h3, 3'h3, 3'h3};
        logic [7:0] fv [7] = '{8'h02, 8'h04, 8'h3E, 8'h00, 8'h3C, 8'h3C, 8'h3C};
        chk("reset level", 16'h4, 16'(isl));
        chk("reset mode", 16'h1, 16'(mode));
        gie = 1'b0;
        for (int i = 0; i < 7; i++) begin
            pulse2(i, i);
            expect_disp(fk[i], (i == 3) ? 3'h2 : 3'h1, fv[i], 16'h0);
            if (i == 3)
                chk("break bank", 16'h5A, 16'(bsel));
            if (i < 2)
                chk("nmi busy", 16'h1, 16'(nmis));
            wait_idle();
        end
    endtask
    task automatic t_maskable();
        int mi [12] = '{7, 8, 9, 10, 11, 12, 14, 15, 18, 13, 16, 17};
        gie = 1'b1;
        for (int i = 0; i < 12; i++) begin
            pulse2(mi[i], mi[i]);
            expect_disp(3'h6, 3'h1, 8'(6 + 2 * (i % 9 + i / 9 * 6)),
                        16'(16'hFE06 + 2 * (i % 9 + i / 9 * 6)));
            wait_idle();
        end
    endtask
    task automatic t_modes();
        use_ctx = 9'h001;
        pulse2(7, 7);
        expect_disp(3'h6, 3'h2, 8'h06, 16'hFE06);
        chk("bank", 16'h06, 16'(bsel));
        wait_idle();
        {use_ctx, use_mac, cap, gie, lvl} = {9'h000, 9'h001, 9'h001, 1'b0, 18'h3FFFF};
        pulse2(7, 7);
        expect_disp(3'h6, 3'h4, 8'h06, 16'hFE06);
        {cap, gie, lvl} = {9'h000, 1'b1, 18'h0};
        repeat (3) @(negedge clk);
        pulse2(7, 7);
        expect_disp(3'h6, 3'h1, 8'h06, 16'hFE06);
        wait_idle();
        use_mac = 9'h000;
    endtask
    task automatic t_gating();
        mask = 9'h001;
        pulse2(7, 7);
        expect_none(10);
        chk("pending", 16'h1, 16'(pend[0]));
        mask = 9'h000;
        expect_disp(3'h6, 3'h1, 8'h06, 16'hFE06);
        wait_idle();
        chk("pending", 16'h0, 16'(pend[0]));
        gie = 1'b0;
        pulse2(8, 8);
        expect_none(10);
        {gie, stall} = 2'b11;
        expect_none(5);
        {stall, ce} = 2'b00;
        expect_none(5);
        chk("frozen pending", 16'h1, 16'(pend[1]));
        ce = 1'b1;
        expect_disp(3'h6, 3'h1, 8'h08, 16'hFE08);
        wait_idle();
    endtask
    task automatic t_prio();
        pulse2(7, 10);
        expect_disp(3'h6, 3'h1, 8'h06, 16'hFE06);
        expect_disp(3'h6, 3'h1, 8'h0C, 16'hFE0C);
        wait_idle();
        lvl = 18'h00002;
        pulse2(7, 10);
        expect_disp(3'h6, 3'h1, 8'h0C, 16'hFE0C);
        expect_disp(3'h6, 3'h1, 8'h06, 16'hFE06);
        wait_idle();
        {lvl, dly} = {18'h000E4, 5'd20};
        pulse2(9, 9);
        expect_disp(3'h6, 3'h1, 8'h0A, 16'hFE0A);
        pulse2(8, 8);
        expect_disp(3'h6, 3'h1, 8'h08, 16'hFE08);
        pulse2(10, 10);
        expect_none(8);
        chk("level", 16'h1, 16'(isl));
        expect_disp(3'h6, 3'h1, 8'h0C, 16'hFE0C);
        wait_idle();
        {lvl, dly} = {18'h0, 5'd2};
        pulse2(0, 7);
        expect_disp(3'h1, 3'h1, 8'h02, 16'h0);
        expect_disp(3'h6, 3'h1, 8'h06, 16'hFE06);
        wait_idle();
        dly = 5'd20;
        pulse2(1, 1);
        expect_disp(3'h2, 3'h1, 8'h04, 16'h0);
        pulse2(0, 0);
        @(negedge clk);
        chk("pin over watchdog", 16'h1, 16'(disp && kind == 3'h1));
        wait_idle();
    endtask
    // ==========================================================
    // Clock, reset, sequence
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        {rst, gie, stall, ce, src, mask, use_ctx, use_mac, cap} = {4'b1001, 19'h0, 36'h0};
        {lvl, bank, dly, miscompares, comparisons} = {18'h0, 8'h5A, 5'd2, 64'h0};
        repeat (4) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        t_fixed();
        t_maskable();
        t_modes();
        t_gating();
        t_prio();
        print_verdict();
    end
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        print_verdict();
    end
endmodule
`default_nettype wire
